// file: slprs_map.vh
// register offsets, fields, resets and codes of the link parameter and status bank
`ifndef SLPRS_MAP_VH
`define SLPRS_MAP_VH
// ==========================================================================
// register indices (byte address is four times the index)
`define SLPRS_IDX_DEVID       10'h206
`define SLPRS_IDX_EOFSEL      10'h207
`define SLPRS_IDX_STATUS      10'h208
`define SLPRS_IDX_CHPAIR      10'h209
`define SLPRS_IDX_CTRL        10'h20A
`define SLPRS_IDX_IRQSTAT     10'h20B
`define SLPRS_IDX_IRQMASK     10'h20C
// ==========================================================================
// reset values
`define SLPRS_RST_DEVID       8'h00
`define SLPRS_RST_EOFSEL      8'h00
`define SLPRS_RST_CHPAIR      8'h03
`define SLPRS_RST_CTRL        8'h00
`define SLPRS_RST_IRQMASK     8'h00
// ==========================================================================
// status field positions
`define SLPRS_ST_LINKUP       6
`define SLPRS_ST_SYNC         5
`define SLPRS_ST_REALIGN      4
`define SLPRS_ST_ALIGN        3
`define SLPRS_ST_SPLL         2
`define SLPRS_ST_CPLL         0
// control register fields
`define SLPRS_CTRL_ENC        0
`define SLPRS_CTRL_M66        1
// ==========================================================================
// end-of-frame selector codes and control characters (8-bit value, k flag apart)
`define SLPRS_EOF_K287        2'h0
`define SLPRS_EOF_K281        2'h1
`define SLPRS_EOF_K285        2'h2
`define SLPRS_CHR_K287        8'hFC
`define SLPRS_CHR_K281        8'h3C
`define SLPRS_CHR_K285        8'hBC
// initial lane alignment: multiframe index and octet index that carry the identifier
`define SLPRS_ILA_IDMF        2'h1
`define SLPRS_ILA_IDOCT       4'h3
`endif

// file: slprs_flag.v
// sticky event flag with write-one-to-clear, set wins over clear
`timescale 1ns/1ps
module slprs_flag (
  sys_clk,
  sys_rst,
  setEv,
  clrEv,
  flag
);
  input  wire sys_clk;
  input  wire sys_rst;
  input  wire setEv;
  input  wire clrEv;
  output reg  flag;

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      flag <= 1'b0;
    end else if (setEv) begin
      flag <= 1'b1;
    end else if (clrEv) begin
      flag <= 1'b0;
    end
  end
endmodule // slprs_flag

// file: slprs_octsel.v
// octet selector for the transmit path: identifier, end-of-frame char, or data
`timescale 1ns/1ps
`include "slprs_map.vh"
module slprs_octsel (
  eofSel,
  devId,
  ilaActive,
  ilaMf,
  ilaOct,
  eofSlot,
  eofFree,
  mode66,
  dataIn,
  octOut,
  octIsK
);
  input  wire [1:0] eofSel;
  input  wire [7:0] devId;
  input  wire       ilaActive;
  input  wire [1:0] ilaMf;
  input  wire [3:0] ilaOct;
  input  wire       eofSlot;
  input  wire       eofFree;
  input  wire       mode66;
  input  wire [7:0] dataIn;
  output reg  [7:0] octOut;
  output reg        octIsK;

  reg [7:0] eofChar;

  always @* begin
    eofChar = `SLPRS_CHR_K287;
    case (eofSel)
      `SLPRS_EOF_K287: eofChar = `SLPRS_CHR_K287;
      `SLPRS_EOF_K281: eofChar = `SLPRS_CHR_K281;
      `SLPRS_EOF_K285: eofChar = `SLPRS_CHR_K285;
      default:         eofChar = `SLPRS_CHR_K287;
    endcase
    octOut = dataIn;
    octIsK = 1'b0;
    if (ilaActive && ilaMf == `SLPRS_ILA_IDMF && ilaOct == `SLPRS_ILA_IDOCT) begin
      octOut = devId;
    end else if (!mode66 && eofSlot && eofFree) begin
      octOut = eofChar;
      octIsK = 1'b1;
    end
  end
endmodule // slprs_octsel

// file: slprs_regs.v
// link parameter and status register bank with avalon-mm slave and interrupt
//
// How it works
// - programmed identifier replaces second-multiframe identifier octet in alignment sequence.
// - selector code 0 K28.7, 1 K28.1, 2 K28.5, 3 reserved.
// - end-of-frame char substituted only where the frame allows it.
// - selection ignored when 64b/66b mode is active.
// - bit 6 reads link up.
// - bit 5 reads 1 when sync deasserted, 0 when asserted.
// - bit 4 sticky on sysref phase shift, write one clears.
// - bit 3 sticky on first sysref after encoder enable, write one clears.
// - bit 2 reads serializer pll lock.
// - bit 0 reads sampling pll lock.
`timescale 1ns/1ps
`include "slprs_map.vh"
module slprs_regs (
  sys_clk,
  sys_rst,
  avsAddress,
  avsRead,
  avsWrite,
  avsWritedata,
  avsByteenable,
  avsReaddata,
  avsWaitrequest,
  linkUp,
  syncReqN,
  sysrefEv,
  phaseShift,
  spllLock,
  cpllLock,
  ilaActive,
  ilaMf,
  ilaOct,
  eofSlot,
  eofFree,
  dataIn,
  txOctet,
  txOctetIsK,
  linkEncoderEnable,
  mode66,
  channelPairEnable,
  irq
);
  input  wire        sys_clk;
  input  wire        sys_rst;
  input  wire [11:0] avsAddress;
  input  wire        avsRead;
  input  wire        avsWrite;
  input  wire [31:0] avsWritedata;
  input  wire [3:0]  avsByteenable;
  output reg  [31:0] avsReaddata;
  output reg         avsWaitrequest;
  input  wire        linkUp;
  input  wire        syncReqN;
  input  wire        sysrefEv;
  input  wire        phaseShift;
  input  wire        spllLock;
  input  wire        cpllLock;
  input  wire        ilaActive;
  input  wire [1:0]  ilaMf;
  input  wire [3:0]  ilaOct;
  input  wire        eofSlot;
  input  wire        eofFree;
  input  wire [7:0]  dataIn;
  output reg  [7:0]  txOctet;
  output reg         txOctetIsK;
  output reg         linkEncoderEnable;
  output reg         mode66;
  output reg  [7:0]  channelPairEnable;
  output reg         irq;

  // ========================================================================
  // register storage
  reg  [7:0] linkDeviceIdentifier_r;
  reg  [7:0] endOfFrameCharSelect_r;
  reg  [7:0] channelPair_r;
  reg  [7:0] ctrl_r;
  reg  [7:0] irqMask_r;
  reg        alignArmed_r;
  reg        busy_r;
  reg  [7:0] statusLive;
  reg  [7:0] rdMux;
  wire       realignFlag;
  wire       alignFlag;
  wire [7:0] octSel;
  wire       octK;
  wire [9:0] regIdx;
  wire       acc;
  wire       wrStb;
  wire       clrStb;
  wire       setRealign;
  wire       setAlign;
  wire [7:0] irqStat;

  assign regIdx = avsAddress[11:2];
  assign acc    = (avsRead | avsWrite) & ~busy_r;
  assign wrStb  = avsWrite & ~avsWaitrequest & avsByteenable[0];

  // ========================================================================
  // bus handshake: one wait cycle, then answer
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_r         <= 1'b0;
      avsWaitrequest <= 1'b1;
      avsReaddata    <= 32'h00000000;
    end else begin
      busy_r         <= acc;
      avsWaitrequest <= ~acc;
      if (acc && avsRead) begin
        avsReaddata <= {24'h000000, rdMux};
      end
    end
  end

  // ========================================================================
  // writable registers
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      linkDeviceIdentifier_r <= `SLPRS_RST_DEVID;
      endOfFrameCharSelect_r <= `SLPRS_RST_EOFSEL;
      channelPair_r          <= `SLPRS_RST_CHPAIR;
      ctrl_r                 <= `SLPRS_RST_CTRL;
      irqMask_r              <= `SLPRS_RST_IRQMASK;
    end else if (wrStb) begin
      case (regIdx)
        `SLPRS_IDX_DEVID:   linkDeviceIdentifier_r <= avsWritedata[7:0];
        `SLPRS_IDX_EOFSEL:  endOfFrameCharSelect_r <= avsWritedata[7:0];
        `SLPRS_IDX_CHPAIR:  channelPair_r          <= avsWritedata[7:0];
        `SLPRS_IDX_CTRL:    ctrl_r                 <= {6'h00, avsWritedata[1:0]};
        `SLPRS_IDX_IRQMASK: irqMask_r              <= {3'h0, avsWritedata[4:3], 3'h0};
        default:            ctrl_r                 <= ctrl_r;
      endcase
    end
  end

  // ========================================================================
  // alignment arming: first sysref after encoder enable
  assign setAlign   = alignArmed_r & sysrefEv & ctrl_r[`SLPRS_CTRL_ENC];
  assign setRealign = phaseShift;
  assign clrStb     = wrStb & (regIdx == `SLPRS_IDX_STATUS || regIdx == `SLPRS_IDX_IRQSTAT);

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      alignArmed_r <= 1'b1;
    end else if (!ctrl_r[`SLPRS_CTRL_ENC]) begin
      alignArmed_r <= 1'b1;
    end else if (sysrefEv) begin
      alignArmed_r <= 1'b0;
    end
  end

  slprs_flag uRealign (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .setEv   (setRealign),
    .clrEv   (clrStb & avsWritedata[`SLPRS_ST_REALIGN]),
    .flag    (realignFlag)
  );

  slprs_flag uAlign (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .setEv   (setAlign),
    .clrEv   (clrStb & avsWritedata[`SLPRS_ST_ALIGN]),
    .flag    (alignFlag)
  );

  // ========================================================================
  // status and read mux
  always @* begin
    statusLive                     = 8'h00;
    statusLive[`SLPRS_ST_LINKUP]   = linkUp;
    statusLive[`SLPRS_ST_SYNC]     = syncReqN;
    statusLive[`SLPRS_ST_REALIGN]  = realignFlag;
    statusLive[`SLPRS_ST_ALIGN]    = alignFlag;
    statusLive[`SLPRS_ST_SPLL]     = spllLock;
    statusLive[`SLPRS_ST_CPLL]     = cpllLock;
  end

  assign irqStat = {3'h0, realignFlag, alignFlag, 3'h0};

  always @* begin
    case (regIdx)
      `SLPRS_IDX_DEVID:   rdMux = linkDeviceIdentifier_r;
      `SLPRS_IDX_EOFSEL:  rdMux = endOfFrameCharSelect_r;
      `SLPRS_IDX_STATUS:  rdMux = statusLive;
      `SLPRS_IDX_CHPAIR:  rdMux = channelPair_r;
      `SLPRS_IDX_CTRL:    rdMux = ctrl_r;
      `SLPRS_IDX_IRQSTAT: rdMux = irqStat;
      `SLPRS_IDX_IRQMASK: rdMux = irqMask_r;
      default:            rdMux = 8'h00;
    endcase
  end

  // ========================================================================
  // transmit octet selection
  slprs_octsel uOct (
    .eofSel    (endOfFrameCharSelect_r[1:0]),
    .devId     (linkDeviceIdentifier_r),
    .ilaActive (ilaActive),
    .ilaMf     (ilaMf),
    .ilaOct    (ilaOct),
    .eofSlot   (eofSlot),
    .eofFree   (eofFree),
    .mode66    (ctrl_r[`SLPRS_CTRL_M66]),
    .dataIn    (dataIn),
    .octOut    (octSel),
    .octIsK    (octK)
  );

  // ========================================================================
  // registered outputs
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      txOctet           <= 8'h00;
      txOctetIsK        <= 1'b0;
      linkEncoderEnable <= 1'b0;
      mode66            <= 1'b0;
      channelPairEnable <= `SLPRS_RST_CHPAIR;
      irq               <= 1'b0;
    end else begin
      txOctet           <= octSel;
      txOctetIsK        <= octK;
      linkEncoderEnable <= ctrl_r[`SLPRS_CTRL_ENC];
      mode66            <= ctrl_r[`SLPRS_CTRL_M66];
      channelPairEnable <= channelPair_r;
      irq               <= |(irqStat & irqMask_r);
    end
  end
endmodule // slprs_regs

// file: slprs_regs_assertions.sv
// checker for the link parameter and status bank
`timescale 1ns/1ps
module slprs_regs_assertions (
  input wire        sys_clk, sys_rst, avsRead, avsWrite, avsWaitrequest,
  input wire [11:0] avsAddress,
  input wire [31:0] avsWritedata, avsReaddata,
  input wire [3:0]  avsByteenable, ilaOct,
  input wire        linkUp, syncReqN, spllLock, cpllLock, mode66,
  input wire        ilaActive, eofSlot, eofFree, txOctetIsK,
  input wire [1:0]  ilaMf,
  input wire [7:0]  dataIn, txOctet
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  reg  [7:0] devId_r;
  wire       rdSt = avsRead && !avsWaitrequest && avsAddress[11:2] == 10'h208;
  wire       wrId = avsWrite && !avsWaitrequest && avsAddress[11:2] == 10'h206;
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst)
      devId_r <= 8'h00;
    else if (wrId && avsByteenable[0])
      devId_r <= avsWritedata[7:0];
  end
  property p_ans;
    (avsRead || avsWrite) && avsWaitrequest |=> !avsWaitrequest;
  endproperty
  a_ans: assert property (p_ans) else $error("late answer");
  property p_link;
    rdSt && $stable(linkUp) |-> avsReaddata[6] == linkUp;
  endproperty
  a_link: assert property (p_link) else $error("link bit");
  property p_sync;
    rdSt && $stable(syncReqN) |-> avsReaddata[5] == syncReqN;
  endproperty
  a_sync: assert property (p_sync) else $error("sync bit");
  property p_pll;
    rdSt && $stable(spllLock) && $stable(cpllLock)
      |-> avsReaddata[2] == spllLock && avsReaddata[0] == cpllLock;
  endproperty
  a_pll: assert property (p_pll) else $error("lock bits");
  property p_eofk;
    eofSlot && eofFree && !mode66 && $stable(mode66) && !ilaActive |=> txOctetIsK;
  endproperty
  a_eofk: assert property (p_eofk) else $error("no control char");
  property p_dat;
    eofSlot && !eofFree && !ilaActive |=> txOctet == $past(dataIn) && !txOctetIsK;
  endproperty
  a_dat: assert property (p_dat) else $error("data replaced");
  property p_m66;
    mode66 && $stable(mode66) && !ilaActive |=> txOctet == $past(dataIn) && !txOctetIsK;
  endproperty
  a_m66: assert property (p_m66) else $error("char in 66b mode");
  property p_ila;
    ilaActive && ilaMf == 2'h1 && ilaOct == 4'h3 |=> txOctet == devId_r && !txOctetIsK;
  endproperty
  a_ila: assert property (p_ila) else $error("identifier octet");
  c_rd: cover property (rdSt);
  c_eof: cover property (eofSlot && eofFree && !mode66 ##1 txOctetIsK);
  c_m66: cover property (mode66 && eofSlot);
endmodule // slprs_regs_assertions
bind slprs_regs slprs_regs_assertions slprs_regs_assertions_i (.*);

// file: slprs_rx_model.sv
// far-end receiver model: sync released on comma, link up after
`timescale 1ns/1ps
module slprs_rx_model (
  input  wire       sys_clk,
  input  wire       sys_rst,
  input  wire [7:0] txOctet,
  input  wire       txOctetIsK,
  output reg        syncReqN,
  output reg        linkUp
);
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      syncReqN <= 1'b0;
      linkUp   <= 1'b0;
    end else if (txOctetIsK) begin
      if (txOctet == 8'hBC)
        syncReqN <= 1'b1;
      linkUp <= syncReqN;
    end
  end
endmodule // slprs_rx_model

// file: slprs_regs_bench.sv
// self-checking bench for the link parameter and status bank
`timescale 1ns/1ps
`include "slprs_map.vh"
module slprs_regs_bench;
  reg         sys_clk, sys_rst, avsRead, avsWrite, sysrefEv, phaseShift;
  reg         spllLock, cpllLock, ilaActive, eofSlot, eofFree;
  reg  [11:0] avsAddress;
  reg  [31:0] avsWritedata;
  reg  [3:0]  avsByteenable, ilaOct;
  reg  [1:0]  ilaMf;
  reg  [7:0]  dataIn, d;
  wire [31:0] avsReaddata;
  wire [7:0]  txOctet, channelPairEnable;
  wire        avsWaitrequest, txOctetIsK, linkEncoderEnable, mode66, irq, linkUp, syncReqN;
  integer     fails, num_checks, c;
  reg  [31:0] q[$];
  slprs_regs slprs_regs_i (.*);
  slprs_rx_model slprs_rx_model_i (.*);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task conclude;
    if (fails == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task chk(input [63:0] nm, input [31:0] e, input [31:0] s);
    num_checks = num_checks + 1;
    if (s !== e) begin
      fails = fails + 1;
      $display("MISMATCH %0s exp %0h got %0h", nm, e, s);
    end
  endtask
  task xfer(input r, input [9:0] a, input [7:0] w, input [3:0] b);
    integer i;
    @(posedge sys_clk);
    avsAddress <= {a, 2'b00};
    avsRead <= r;
    avsWrite <= !r;
    avsWritedata <= {24'h000000, w};
    avsByteenable <= b;
    i = 0;
    do begin
      @(posedge sys_clk);
      i = i + 1;
    end while (avsWaitrequest !== 1'b0 && i < 20);
    if (avsWaitrequest !== 1'b0) begin
      fails = fails + 1;
      conclude;
    end
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
  endtask
  task rd(input [9:0] a, input [7:0] e);
    q.push_back({24'h000000, e});
    xfer(1'b1, a, 8'h00, 4'hF);
  endtask
  task tx(input a, input s, input f, input dv, input [8:0] e);
    @(posedge sys_clk);
    ilaActive <= a;
    eofSlot <= s;
    eofFree <= f;
    dataIn <= d;
    @(posedge sys_clk);
    #1 chk("octet", dv ? {23'h0, 1'b0, d} : {23'h0, e}, {23'h0, txOctetIsK, txOctet});
  endtask
  task pulse(input p);
    @(posedge sys_clk);
    phaseShift <= p;
    sysrefEv <= !p;
    @(posedge sys_clk);
    phaseShift <= 1'b0;
    sysrefEv <= 1'b0;
  endtask
  always @(posedge sys_clk) begin
    if (avsRead && avsWaitrequest === 1'b0)
      chk("readdata", q.pop_front(), avsReaddata);
  end
  initial begin
    {fails, num_checks, avsRead, avsWrite, sysrefEv, phaseShift, cpllLock} = 0;
    {ilaActive, eofSlot, eofFree, avsAddress, avsWritedata, avsByteenable, dataIn} = 0;
    spllLock = 1'b1;
    ilaMf = 2'h1;
    ilaOct = 4'h3;
    sys_rst = 1'b1;
    d = $urandom(29067);
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(`SLPRS_IDX_DEVID, `SLPRS_RST_DEVID);
    rd(`SLPRS_IDX_EOFSEL, `SLPRS_RST_EOFSEL);
    rd(`SLPRS_IDX_CHPAIR, `SLPRS_RST_CHPAIR);
    rd(10'h0F0, 8'h00);
    rd(`SLPRS_IDX_STATUS, 8'h04);
    #1 chk("chpair", 32'h3, {24'h0, channelPairEnable});
    xfer(1'b0, `SLPRS_IDX_DEVID, d, 4'h1);
    xfer(1'b0, `SLPRS_IDX_DEVID, ~d, 4'h0);
    rd(`SLPRS_IDX_DEVID, d);
    tx(1'b1, 1'b0, 1'b0, 1'b0, {1'b0, d});
    for (c = 0; c < 4; c = c + 1) begin
      xfer(1'b0, `SLPRS_IDX_EOFSEL, c[7:0], 4'h1);
      tx(1'b0, 1'b1, 1'b1, 1'b0, {1'b1, c == 1 ? `SLPRS_CHR_K281 :
         c == 2 ? `SLPRS_CHR_K285 : `SLPRS_CHR_K287});
    end
    xfer(1'b0, `SLPRS_IDX_EOFSEL, 8'h00, 4'h1);
    rd(`SLPRS_IDX_EOFSEL, 8'h00);
    d = $urandom;
    tx(1'b0, 1'b1, 1'b0, 1'b1, 9'h000);
    xfer(1'b0, `SLPRS_IDX_CTRL, 8'h02, 4'h1);
    repeat (2) @(posedge sys_clk);
    #1 chk("ctrlout", 32'h2, {30'h0, mode66, linkEncoderEnable});
    tx(1'b0, 1'b1, 1'b1, 1'b1, 9'h000);
    eofSlot <= 1'b0;
    cpllLock <= 1'b1;
    xfer(1'b0, `SLPRS_IDX_IRQMASK, 8'h18, 4'h1);
    pulse(1'b0);
    pulse(1'b1);
    rd(`SLPRS_IDX_STATUS, 8'h75);
    #1 chk("irq", 32'h1, {31'h0, irq});
    xfer(1'b0, `SLPRS_IDX_CTRL, 8'h01, 4'h1);
    repeat (2) @(posedge sys_clk);
    #1 chk("ctrlout", 32'h1, {30'h0, mode66, linkEncoderEnable});
    pulse(1'b0);
    rd(`SLPRS_IDX_STATUS, 8'h7D);
    xfer(1'b0, `SLPRS_IDX_STATUS, 8'h18, 4'h1);
    rd(`SLPRS_IDX_STATUS, 8'h65);
    #1 chk("irq", 32'h0, {31'h0, irq});
    xfer(1'b0, `SLPRS_IDX_IRQMASK, 8'h00, 4'h1);
    pulse(1'b1);
    rd(`SLPRS_IDX_IRQSTAT, 8'h10);
    #1 chk("irq", 32'h0, {31'h0, irq});
    xfer(1'b0, `SLPRS_IDX_IRQSTAT, 8'h10, 4'h1);
    rd(`SLPRS_IDX_IRQSTAT, 8'h00);
    conclude;
  end
endmodule // slprs_regs_bench
